// ===== hw/a16_config_map.svh
`ifndef A16_CONFIG_MAP_SVH
`define A16_CONFIG_MAP_SVH

// Word offsets in A16 space (byte addresses)
`define OFS_IDENT_CTRL      6'h00
`define OFS_DEVICE_TYPE     6'h02
`define OFS_STATUS_CONTROL  6'h04
`define OFS_MEMORY_BASE     6'h06
`define OFS_RESERVED_A      6'h08
`define OFS_RESERVED_B      6'h0a
`define OFS_RESERVED_C      6'h0c
`define OFS_VERSION         6'h0e

// Identification word fields
`define IDENT_CLASS_EXT_REG 2'h1
`define IDENT_SPACE_A24     2'h0
`define IDENT_SPACE_A32     2'h1

// Device type required-memory codes for 2 MB
`define REQ_MEM_A24         4'h2
`define REQ_MEM_A32         4'ha

// Control bit positions
`define CTRL_MEM_ENABLE_BIT 15
`define CTRL_SYSFAIL_INH_BIT 1
`define CTRL_SOFT_RESET_BIT 0

// Reset values and fixed read values
`define NODE_NUMBER_RESET   8'hff
`define MEM_BASE_RESET      16'h0000
`define MEM_BASE_LOW_MASK   16'hffe0
`define STATUS_FIXED_ONES   14'h3fff
`define RESERVED_READ       16'hffff
`define FIRMWARE_VERSION    8'h00

`endif

// ===== hw/a16_config_pkg.sv
package a16_config_pkg;

    // Width of one backplane register word
    typedef logic [15:0] word_t;

    // Extended-memory address mode chosen by the board strap
    typedef enum logic [0:0]
    {
        space_a24 = 1'b0,
        space_a32 = 1'b1
    } space_e;

endpackage

// ===== hw/a16_config_register_bank.sv
// Notes on behaviour
// - Ident word: maker code, space, class 01
// - Write offset zero loads node number
// - Soft reset keeps node; hard sets FF
// - Node number write ignores upper byte
// - Device type: model, memory code 2/A
// - Status bit 15 shows memory enable
// - Status bit 14 shows identify select
// - Other status bits always read one
// - Control bit 15 enables memory access
// - Inhibit bit blocks system-fail drive
// - Control bit 0 holds soft reset
// - Soft reset clears enable and inhibit
// - Control bits 14 to 2 ignored
// - Base is offset times 256 or 65536
// - Offset reads back, low five zero
// - Hard reset clears offset; soft keeps
// - Reserved words read all ones
// - Version: firmware 00, hardware revision
`include "a16_config_map.svh"

module a16_config_register_bank
    import a16_config_pkg::*;
#(
    parameter logic [11:0] maker_code  = 12'h5a5, // Arbitrary value
    parameter logic [11:0] model_code  = 12'h0a1, // Arbitrary value
    parameter logic [7:0]  hw_revision = 8'h01
)
(
    // Clock, reset and enable
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic        clock_enable,
    // Board strap: high selects A32 extended space
    input  wire logic        mode_a32,
    // Register access port
    input  wire logic [5:0]  address,
    input  wire logic        write_strobe,
    input  wire logic        read_strobe,
    input  wire word_t       write_data,
    output word_t            read_data,
    output logic             read_valid,
    // Backplane status
    input  wire logic        module_identify_select_n,
    input  wire logic        fault_request,
    output logic             sysfail_n,
    // Configuration results
    output logic [7:0]       bus_node_number,
    output logic             mem_enable,
    output logic             soft_reset_active,
    output logic [31:0]      memory_base_address
);

    word_t       memory_base_offset;
    logic        sysfail_inhibit;
    word_t       read_value;

    // Write decode; shared offsets route writes to the write-only registers
    wire logic write_node = write_strobe &&
        address == `OFS_IDENT_CTRL;
    wire logic write_ctrl = write_strobe &&
        address == `OFS_STATUS_CONTROL;
    wire logic write_base = write_strobe &&
        address == `OFS_MEMORY_BASE;
    // The soft reset bit itself must stay writable to release the state
    wire logic interface_held = soft_reset_active && !write_ctrl;

    // Node number: only the hard reset returns it to the dynamic value
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            bus_node_number <= `NODE_NUMBER_RESET;
        else if (clock_enable && write_node)
            bus_node_number <= write_data[7:0];
    end

    // Soft reset control; bits 14 to 2 have nowhere to go
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            soft_reset_active <= 1'b0;
        else if (clock_enable && write_ctrl)
            soft_reset_active <=
                write_data[`CTRL_SOFT_RESET_BIT];
    end

    // Interface registers cleared while soft reset holds them
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            mem_enable      <= 1'b0;
            sysfail_inhibit <= 1'b0;
        end
        else if (clock_enable)
        begin
            if (write_ctrl)
            begin
                mem_enable      <= write_data[`CTRL_MEM_ENABLE_BIT];
                sysfail_inhibit <= write_data[`CTRL_SYSFAIL_INH_BIT];
            end
            else if (interface_held)
            begin
                mem_enable      <= 1'b0;
                sysfail_inhibit <= 1'b0;
            end
        end
    end

    // Offset survives soft reset; low bits never stored
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            memory_base_offset <= `MEM_BASE_RESET;
        else if (clock_enable && write_base)
            memory_base_offset <=
                write_data & `MEM_BASE_LOW_MASK;
    end

    // Base address scaled by the selected space
    assign memory_base_address = mode_a32
        ? {memory_base_offset, 16'h0000}
        : {8'h00, memory_base_offset, 8'h00};

    // Failure line; soft reset clears the inhibit, so a fault request then drives it
    assign sysfail_n = !(fault_request && !sysfail_inhibit);

    read_mux #(
        .maker_code  (maker_code),
        .model_code  (model_code),
        .hw_revision (hw_revision)
    ) u_read_mux (
        .address                  (address),
        .mode_a32                 (mode_a32),
        .mem_enable               (mem_enable),
        .module_identify_select_n (module_identify_select_n),
        .memory_base_offset       (memory_base_offset),
        .read_value               (read_value)
    );

    // Read data registered one cycle after the strobe
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            read_data  <= 16'h0000;
            read_valid <= 1'b0;
        end
        else if (clock_enable)
        begin
            read_valid <= read_strobe;
            if (read_strobe)
                read_data <= read_value;
        end
    end

    // Checks: each sits beside the rule it guards; all but the first are
    // off during hard reset, since every flop is forced then and the
    // sampled history of that window means nothing

    // Node number register; only a hard reset may bring back FF
    node_hard_a: assert property (
        @(posedge clock)
        $rose(resetn) |-> bus_node_number == `NODE_NUMBER_RESET)
        else $error("node number not FF after hard reset");

    node_write_a: assert property (
        @(posedge clock) disable iff (!resetn)
        clock_enable && write_node |=>
        bus_node_number == $past(write_data[7:0]))
        else $error("node number write lost");

    node_soft_a: assert property (
        @(posedge clock) disable iff (!resetn)
        soft_reset_active && !write_node |=> $stable(bus_node_number))
        else $error("soft reset altered node number");

    node_hold_a: assert property (
        @(posedge clock) disable iff (!resetn)
        !(clock_enable && write_node) |=> $stable(bus_node_number))
        else $error("node number changed without a write");

    // Control register; a control write always wins over the held
    // soft reset so that the bit can be released
    soft_set_a: assert property (
        @(posedge clock) disable iff (!resetn)
        clock_enable && write_ctrl |=>
        soft_reset_active == $past(write_data[0]))
        else $error("soft reset bit not written");

    soft_keep_a: assert property (
        @(posedge clock) disable iff (!resetn)
        !(clock_enable && write_ctrl) |=> $stable(soft_reset_active))
        else $error("soft reset bit changed without a write");

    mem_enable_a: assert property (
        @(posedge clock) disable iff (!resetn)
        clock_enable && write_ctrl |=> mem_enable == $past(write_data[15]))
        else $error("memory enable not written");

    soft_hold_a: assert property (
        @(posedge clock) disable iff (!resetn)
        clock_enable && soft_reset_active && !write_ctrl |=> !mem_enable)
        else $error("soft reset did not clear enable");

    inhibit_write_a: assert property (
        @(posedge clock) disable iff (!resetn)
        clock_enable && write_ctrl |=>
        sysfail_inhibit == $past(write_data[1]))
        else $error("inhibit bit not written");

    inhibit_clear_a: assert property (
        @(posedge clock) disable iff (!resetn)
        clock_enable && soft_reset_active && !write_ctrl |=> !sysfail_inhibit)
        else $error("soft reset did not clear inhibit");

    enable_freeze_a: assert property (
        @(posedge clock) disable iff (!resetn)
        !clock_enable |=> $stable(mem_enable))
        else $error("memory enable moved while frozen");

    inhibit_freeze_a: assert property (
        @(posedge clock) disable iff (!resetn)
        !clock_enable |=> $stable(sysfail_inhibit))
        else $error("inhibit moved while frozen");

    // Offset register and the base address derived from it
    base_low_a: assert property (
        @(posedge clock) disable iff (!resetn)
        memory_base_offset[4:0] == 5'h00)
        else $error("offset low bits not zero");

    base_write_a: assert property (
        @(posedge clock) disable iff (!resetn)
        clock_enable && write_base |=>
        memory_base_offset == ($past(write_data) & `MEM_BASE_LOW_MASK))
        else $error("offset write lost");

    base_keep_a: assert property (
        @(posedge clock) disable iff (!resetn)
        soft_reset_active && !write_base |=> $stable(memory_base_offset))
        else $error("soft reset altered offset");

    base_hold_a: assert property (
        @(posedge clock) disable iff (!resetn)
        !(clock_enable && write_base) |=> $stable(memory_base_offset))
        else $error("offset changed without a write");

    base_addr_a: assert property (
        @(posedge clock) disable iff (!resetn)
        !mode_a32 |-> memory_base_address[7:0] == 8'h00 &&
        memory_base_address[23:8] == memory_base_offset)
        else $error("A24 base address wrong");

    base_a24_top_a: assert property (
        @(posedge clock) disable iff (!resetn)
        !mode_a32 |-> memory_base_address[31:24] == 8'h00)
        else $error("A24 base address upper byte not zero");

    base_a32_a: assert property (
        @(posedge clock) disable iff (!resetn)
        mode_a32 |-> memory_base_address == {memory_base_offset, 16'h0000})
        else $error("A32 base address wrong");

    // System-fail line; combinational, so checked in the same cycle
    sysfail_inh_a: assert property (
        @(posedge clock) disable iff (!resetn)
        sysfail_inhibit |-> sysfail_n)
        else $error("system fail driven while inhibited");

    sysfail_fault_a: assert property (
        @(posedge clock) disable iff (!resetn)
        fault_request && !sysfail_inhibit |-> !sysfail_n)
        else $error("system fail not driven on a fault");

    sysfail_idle_a: assert property (
        @(posedge clock) disable iff (!resetn)
        !fault_request |-> sysfail_n)
        else $error("system fail driven without a fault");

    // Read path; the answer always comes one enabled cycle after the
    // strobe and holds until the next read
    valid_pulse_a: assert property (
        @(posedge clock) disable iff (!resetn)
        clock_enable |=> read_valid == $past(read_strobe))
        else $error("read valid does not follow the strobe");

    valid_freeze_a: assert property (
        @(posedge clock) disable iff (!resetn)
        !clock_enable |=> $stable(read_valid))
        else $error("read valid moved while frozen");

    data_hold_a: assert property (
        @(posedge clock) disable iff (!resetn)
        !(clock_enable && read_strobe) |=> $stable(read_data))
        else $error("read data changed without a read");

    status_read_a: assert property (
        @(posedge clock) disable iff (!resetn)
        clock_enable && read_strobe && address == `OFS_STATUS_CONTROL |=>
        read_data == {$past(mem_enable), $past(module_identify_select_n),
                      `STATUS_FIXED_ONES})
        else $error("status word wrong");

    reserved_a: assert property (
        @(posedge clock) disable iff (!resetn)
        clock_enable && read_strobe && address == `OFS_RESERVED_B |=>
        read_data == `RESERVED_READ)
        else $error("reserved word not all ones");

    reserved_ac_a: assert property (
        @(posedge clock) disable iff (!resetn)
        clock_enable && read_strobe &&
        (address == `OFS_RESERVED_A || address == `OFS_RESERVED_C) |=>
        read_data == `RESERVED_READ)
        else $error("reserved word not all ones");

    unmapped_a: assert property (
        @(posedge clock) disable iff (!resetn)
        clock_enable && read_strobe && address == 6'h10 |=>
        read_data == `RESERVED_READ)
        else $error("unmapped word not all ones");

    ident_read_a: assert property (
        @(posedge clock) disable iff (!resetn)
        clock_enable && read_strobe && address == `OFS_IDENT_CTRL |=>
        read_data[15:12] == {2'b01, 1'b0, $past(mode_a32)})
        else $error("ident class or space wrong");

    ident_low_a: assert property (
        @(posedge clock) disable iff (!resetn)
        clock_enable && read_strobe && address == `OFS_IDENT_CTRL |=>
        read_data[11:0] == maker_code)
        else $error("ident maker code wrong");

    type_read_a: assert property (
        @(posedge clock) disable iff (!resetn)
        clock_enable && read_strobe && address == `OFS_DEVICE_TYPE |=>
        read_data[15:12] == ($past(mode_a32) ? 4'ha : 4'h2))
        else $error("device type memory code wrong");

    type_low_a: assert property (
        @(posedge clock) disable iff (!resetn)
        clock_enable && read_strobe && address == `OFS_DEVICE_TYPE |=>
        read_data[11:0] == model_code)
        else $error("device type model code wrong");

    version_read_a: assert property (
        @(posedge clock) disable iff (!resetn)
        clock_enable && read_strobe && address == `OFS_VERSION |=>
        read_data[15:8] == 8'h00)
        else $error("firmware version not zero");

    version_low_a: assert property (
        @(posedge clock) disable iff (!resetn)
        clock_enable && read_strobe && address == `OFS_VERSION |=>
        read_data[7:0] == hw_revision)
        else $error("hardware revision wrong");

    base_read_a: assert property (
        @(posedge clock) disable iff (!resetn)
        clock_enable && read_strobe && address == `OFS_MEMORY_BASE |=>
        read_data == $past(memory_base_offset))
        else $error("offset read back wrong");

endmodule

// ===== hw/read_mux.sv
`include "a16_config_map.svh"

// Read data selection for the A16 configuration words
module read_mux
    import a16_config_pkg::*;
#(
    parameter logic [11:0] maker_code = 12'h5a5, // Arbitrary value
    parameter logic [11:0] model_code = 12'h0a1, // Arbitrary value
    parameter logic [7:0]  hw_revision = 8'h01
)
(
    // Selection
    input  wire logic [5:0]  address,
    input  wire logic        mode_a32,
    // Register state
    input  wire logic        mem_enable,
    input  wire logic        module_identify_select_n,
    input  wire word_t       memory_base_offset,
    // Result
    output word_t            read_value
);

    // Words assembled from straps, parameters and register state
    wire word_t identification_word =
        {`IDENT_CLASS_EXT_REG,
         mode_a32 ? `IDENT_SPACE_A32 : `IDENT_SPACE_A24,
         maker_code};
    wire word_t device_type_word =
        {mode_a32 ? `REQ_MEM_A32 : `REQ_MEM_A24, model_code};
    wire word_t status_word =
        {mem_enable, module_identify_select_n,
         `STATUS_FIXED_ONES};
    wire word_t version_word = {`FIRMWARE_VERSION, hw_revision};

    // Unmapped words read as all ones like the reserved words
    always_comb
    begin
        unique case (address)
            `OFS_IDENT_CTRL:     read_value = identification_word;
            `OFS_DEVICE_TYPE:    read_value = device_type_word;
            `OFS_STATUS_CONTROL: read_value = status_word;
            `OFS_MEMORY_BASE:    read_value = memory_base_offset;
            `OFS_RESERVED_A,
            `OFS_RESERVED_B,
            `OFS_RESERVED_C:     read_value = `RESERVED_READ;
            `OFS_VERSION:        read_value = version_word;
            default:             read_value = `RESERVED_READ;
        endcase
    end

endmodule

// ===== testbench/a16_config_register_bank_bench.sv
module a16_config_register_bank_bench;
    import a16_config_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] maker = 12'h3c7; // Arbitrary value
    localparam logic [11:0] model = 12'h2d1; // Arbitrary value
    localparam logic [7:0]  rev   = 8'h4e;
    logic        clock, resetn, clock_enable, mode_a32;
    logic        module_identify_select_n, fault_request;
    logic [5:0]  address;
    logic        write_strobe, read_strobe, read_valid;
    word_t       write_data, read_data, q;
    logic        sysfail_n, mem_enable, soft_reset_active;
    logic [7:0]  bus_node_number, node_now;
    logic [31:0] memory_base_address;
    int          miscompares, samples_checked;
    bit          ok;

    a16_config_register_bank #(.maker_code(maker), .model_code(model),
        .hw_revision(rev)) i_dut (.*);
    a16_controller_model i_ctrl (.*);

    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic finish_test;
        $display("compared %0d mismatched %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(string what, logic [31:0] e, logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic wr(logic [5:0] ofs, word_t d);
        i_ctrl.access(1'b1, node_now, ofs, d, q, ok);
    endtask

    // A missing answer is a mismatch and ends the run
    task automatic rd(string what, logic [5:0] ofs, word_t e);
        i_ctrl.access(1'b0, node_now, ofs, 16'h0000, q, ok);
        if (!ok)
        begin
            miscompares++;
            finish_test();
        end
        check(what, {16'h0000, e}, {16'h0000, q});
    endtask

    task automatic hard_reset;
        @(posedge clock);
        resetn <= 1'b0;
        repeat (12) @(posedge clock);
        resetn <= 1'b1;
        node_now = 8'hff;
    endtask

    task automatic reset_values;
        check("node", 8'hff, bus_node_number);
        rd("offset", 6'h06, 16'h0000);
        rd("status", 6'h04, {2'b01, 14'h3fff});
    endtask

    task automatic ident_type;
        for (int m = 0; m < 2; m++)
        begin
            @(posedge clock);
            mode_a32 <= m[0];
            rd("ident", 6'h00, {3'b010, m[0], maker});
            rd("type", 6'h02, {m[0] ? 4'ha : 4'h2, model});
        end
    endtask

    task automatic node_write;
        wr(6'h00, 16'hab37);
        check("node", 8'h37, bus_node_number);
        node_now = 8'h37;
        rd("ident", 6'h00, {4'b0101, maker});
    endtask

    // Inhibit set while a fault is requested keeps the line released
    task automatic control_bits;
        @(posedge clock);
        fault_request <= 1'b1;
        module_identify_select_n <= 1'b0;
        wr(6'h04, 16'h8002);
        check("enable", 1, mem_enable);
        check("sysfail", 1, sysfail_n);
        rd("status", 6'h04, {2'b10, 14'h3fff});
        wr(6'h04, 16'h7ffc);
        check("enable", 0, mem_enable);
        check("sysfail", 0, sysfail_n);
        check("soft", 0, soft_reset_active);
        @(posedge clock);
        module_identify_select_n <= 1'b1;
        fault_request <= 1'b0;
    endtask

    task automatic offset_map;
        wr(6'h06, 16'h1234);
        rd("offset", 6'h06, 16'h1220);
        for (int m = 0; m < 2; m++)
        begin
            @(posedge clock);
            mode_a32 <= m[0];
            @(posedge clock);
            #1;
            check("base", m ? 32'h12200000 : 32'h00122000,
                memory_base_address);
        end
    endtask

    task automatic soft_reset;
        wr(6'h04, 16'h8003);
        rd("status", 6'h04, {2'b01, 14'h3fff});
        check("soft", 1, soft_reset_active);
        check("node", 8'h37, bus_node_number);
        rd("offset", 6'h06, 16'h1220);
        wr(6'h04, 16'h0000);
        wr(6'h04, 16'h8000);
        check("soft", 0, soft_reset_active);
        check("enable", 1, mem_enable);
    endtask

    // Writes to read-only and frozen cycles must leave state alone
    task automatic fixed_words;
        wr(6'h02, 16'h0000);
        wr(6'h08, 16'h0000);
        wr(6'h0e, 16'h0000);
        for (int a = 8; a < 13; a += 2)
            rd("reserved", a[5:0], 16'hffff);
        rd("version", 6'h0e, {8'h00, rev});
        rd("type", 6'h02, {4'ha, model});
        rd("unmapped", 6'h10, 16'hffff);
        @(posedge clock);
        clock_enable <= 1'b0;
        wr(6'h06, 16'hffff);
        @(posedge clock);
        clock_enable <= 1'b1;
        rd("offset", 6'h06, 16'h1220);
    endtask

    initial
    begin
        resetn = 1'b0;
        clock_enable = 1'b1;
        mode_a32 = 1'b0;
        module_identify_select_n = 1'b1;
        fault_request = 1'b0;
        hard_reset();
        reset_values();
        ident_type();
        node_write();
        control_bits();
        offset_map();
        soft_reset();
        fixed_words();
        hard_reset();
        reset_values();
        finish_test();
    end
endmodule

// ===== testbench/a16_controller_model.sv
// Backplane controller: builds the A16 address from the node number, drives only its low six bits, one word a request
module a16_controller_model
(
    // Clock
    input  wire logic        clock,
    // Requests
    output logic [5:0]       address,
    output logic             write_strobe,
    output logic             read_strobe,
    output logic [15:0]      write_data,
    // Answers
    input  wire logic [15:0] read_data,
    input  wire logic        read_valid
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        address = 6'h00;
        write_strobe = 1'b0;
        read_strobe = 1'b0;
        write_data = 16'h0000;
    end

    // Released lines show the inverse so stale values never match
    task automatic access(input bit wr, input logic [7:0] node,
        input logic [5:0] ofs, input logic [15:0] d,
        output logic [15:0] q, output bit ok);
        logic [15:0] a16;
        a16 = {8'h00, node} * 16'h0040 + 16'hc000 + {10'h000, ofs};
        @(posedge clock);
        address <= a16[5:0];
        write_data <= d;
        write_strobe <= wr;
        read_strobe <= !wr;
        @(posedge clock);
        write_strobe <= 1'b0;
        read_strobe <= 1'b0;
        address <= ~a16[5:0];
        write_data <= ~d;
        ok = wr;
        q = 16'h0000;
        #1;
        for (int i = 0; i < 4 && !ok; i++)
            if (read_valid === 1'b1)
            begin
                q = read_data;
                ok = 1'b1;
            end
            else
            begin
                @(posedge clock);
                #1;
            end
    endtask
endmodule
